// *** vsi_core.sv ***
// Serial link, event flags, open-drain interrupt and sample clock divider.

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Pull interrupt low on memory or message end
// - Ending operation by either event raises interrupt
// - Next serial transaction start clears interrupt
// - Status readable by read-event instruction
// - Memory end flag on array end, record/play
// - Message end flag only in play or cue, eight markers
// - External sample clock divided by two at entry
// - Capture on rising, shift out on falling
// - Words travel least significant bit first
// - Status shifts out while control shifts in
module vsi_core
	import vsi_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic sclk_in,
	input wire logic select_n_in,
	input wire logic mosi_in,
	input wire logic external_sample_clock_in,
	input wire logic [1:0] op_mode_in,
	input wire logic array_end_in,
	input wire logic [MARKERS_PER_ROW-1:0] marker_hit_in,
	output logic miso_out,
	output logic miso_oe_out,
	output logic int_n_out,
	output logic int_oe_out,
	output logic sample_tick_out,
	output logic [FRAME_BITS-1:0] frame_out,
	output logic frame_valid_out,
	output logic read_event_out
);

	////////////////////////////////////////////////////////////////////////
	// Reset release.
	logic rst_meta_ff;
	logic rst_sync_ff;
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	wire logic rstn = rst_sync_ff;

	////////////////////////////////////////////////////////////////////////
	// Edge detection on serial pins and the sample clock input.
	// Inputs are synchronous to sys_clk, so one stage gives the edges.
	logic sclk_d_ff;
	logic sel_d_ff;
	logic external_sample_clock_d_ff;
	always_ff @(posedge sys_clk_in or negedge rstn) begin
		if (!rstn) begin
			sclk_d_ff <= 1'b0;
			sel_d_ff <= 1'b1;
			external_sample_clock_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_in;
			sel_d_ff <= select_n_in;
			external_sample_clock_d_ff <= external_sample_clock_in;
		end
	end
	// The host alone makes sclk; it is only sampled here.
	wire logic sclk_rise = sclk_in & ~sclk_d_ff;
	wire logic sclk_fall = ~sclk_in & sclk_d_ff;
	wire logic sel_start = ~select_n_in & sel_d_ff;
	wire logic sel_end = select_n_in & ~sel_d_ff;
	wire logic external_sample_clock_rise = external_sample_clock_in & ~external_sample_clock_d_ff;

	////////////////////////////////////////////////////////////////////////
	// Sample clock divide by two; only rising edges count, so the duty
	// cycle does not matter. A grounded input gives no ticks.
	logic div_ff;
	logic nxt_div;
	logic tick_ff;
	logic nxt_tick;
	always_comb begin
		nxt_div = div_ff ^ external_sample_clock_rise;
		nxt_tick = external_sample_clock_rise & div_ff;
	end
	always_ff @(posedge sys_clk_in or negedge rstn) begin
		if (!rstn) begin
			div_ff <= 1'b0;
			tick_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial shifter and event flags.
	vsi_state_t state_ff;
	vsi_state_t nxt_state;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [FRAME_BITS-1:0] rx_ff;
	logic [FRAME_BITS-1:0] nxt_rx;
	logic [1:0] tx_ff;
	logic [1:0] nxt_tx;
	logic mem_end_flag_ff;
	logic nxt_mem_end_flag;
	logic msg_end_flag_ff;
	logic nxt_msg_end_flag;
	logic miso_ff;
	logic nxt_miso;
	logic miso_oe_ff;
	logic nxt_miso_oe;
	logic valid_ff;
	logic nxt_valid;
	logic rd_ev_ff;
	logic nxt_rd_ev;
	logic [FRAME_BITS-1:0] frame_ff;
	logic [FRAME_BITS-1:0] nxt_frame;
	logic mem_end_ev;
	logic msg_end_ev;

	always_comb begin
		// Memory end during record or playback only.
		mem_end_ev = array_end_in &
			(op_mode_in == OP_RECORD || op_mode_in == OP_PLAY);
		// Any of the eight row markers, found while playing or cueing.
		msg_end_ev = (|marker_hit_in) &
			(op_mode_in == OP_PLAY || op_mode_in == OP_CUE);
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_rx = rx_ff;
		nxt_tx = tx_ff;
		nxt_mem_end_flag = mem_end_flag_ff;
		nxt_msg_end_flag = msg_end_flag_ff;
		nxt_miso = miso_ff;
		nxt_miso_oe = miso_oe_ff;
		nxt_valid = 1'b0;
		nxt_rd_ev = 1'b0;
		nxt_frame = frame_ff;
		if (sel_start) begin
			// Snapshot status to shift out, then clear the flags.
			nxt_tx = {msg_end_flag_ff, mem_end_flag_ff};
			nxt_mem_end_flag = 1'b0;
			nxt_msg_end_flag = 1'b0;
			nxt_miso = mem_end_flag_ff;
			nxt_miso_oe = 1'b1;
			nxt_cnt = 4'h0;
			nxt_state = VSI_SHIFT;
		end
		// Set wins over the clear above, so a same-cycle event survives.
		if (mem_end_ev) begin
			nxt_mem_end_flag = 1'b1;
		end
		if (msg_end_ev) begin
			nxt_msg_end_flag = 1'b1;
		end
		case (state_ff)
			VSI_IDLE: begin
			end
			VSI_SHIFT: begin
				if (sclk_rise) begin
					// Least significant bit arrives first.
					nxt_rx = {mosi_in, rx_ff[FRAME_BITS-1:1]};
					nxt_cnt = cnt_ff + 4'h1;
					if (cnt_ff == BIT_CNT_LAST) begin
						nxt_state = VSI_DONE;
					end
				end
				if (sclk_fall) begin
					// Next status bit goes out on the falling edge.
					nxt_tx = {1'b0, tx_ff[1]};
					nxt_miso = tx_ff[1];
				end
				if (sel_end) begin
					nxt_miso_oe = 1'b0;
					nxt_state = VSI_IDLE;
				end
			end
			VSI_DONE: begin
				if (sclk_fall) begin
					nxt_miso = 1'b0;
				end
				if (sel_end) begin
					nxt_miso_oe = 1'b0;
					nxt_valid = 1'b1;
					nxt_frame = rx_ff;
					// Control bits sit in the top five of the frame.
					nxt_rd_ev = (rx_ff[FRAME_BITS-1:FRAME_BITS-5] ==
						CMD_READ_EVENT);
					nxt_state = VSI_IDLE;
				end
			end
			default: begin
				nxt_state = VSI_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rstn) begin
		if (!rstn) begin
			state_ff <= VSI_IDLE;
			cnt_ff <= 4'h0;
			rx_ff <= '0;
			tx_ff <= 2'h0;
			mem_end_flag_ff <= 1'b0;
			msg_end_flag_ff <= 1'b0;
			miso_ff <= 1'b0;
			miso_oe_ff <= 1'b0;
			valid_ff <= 1'b0;
			rd_ev_ff <= 1'b0;
			frame_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			rx_ff <= nxt_rx;
			tx_ff <= nxt_tx;
			mem_end_flag_ff <= nxt_mem_end_flag;
			msg_end_flag_ff <= nxt_msg_end_flag;
			miso_ff <= nxt_miso;
			miso_oe_ff <= nxt_miso_oe;
			valid_ff <= nxt_valid;
			rd_ev_ff <= nxt_rd_ev;
			frame_ff <= nxt_frame;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Open-drain interrupt: drive low while any flag stands.
	logic int_oe_ff;
	logic nxt_int_oe;
	always_comb begin
		nxt_int_oe = nxt_mem_end_flag | nxt_msg_end_flag;
	end
	always_ff @(posedge sys_clk_in or negedge rstn) begin
		if (!rstn) begin
			int_oe_ff <= 1'b0;
		end else begin
			int_oe_ff <= nxt_int_oe;
		end
	end

	assign miso_out = miso_ff;
	assign miso_oe_out = miso_oe_ff;
	assign int_n_out = 1'b0;
	assign int_oe_out = int_oe_ff;
	assign sample_tick_out = tick_ff;
	assign frame_out = frame_ff;
	assign frame_valid_out = valid_ff;
	assign read_event_out = rd_ev_ff;

endmodule : vsi_core

// *** vsi_pkg.sv ***
// Constants shared by the voice store interrupt and clock block.
package vsi_pkg;
	localparam int unsigned SYS_CLK_HZ = 20000000;
	localparam int unsigned FRAME_BITS = 16;
	localparam logic [3:0] BIT_CNT_LAST = 4'hf;
	localparam int unsigned MARKERS_PER_ROW = 8;
	localparam int unsigned STATUS_MEM_END_BIT = 0;
	localparam int unsigned STATUS_MSG_END_BIT = 1;
	localparam logic [4:0] CMD_READ_EVENT = 5'h0c;
	localparam logic [1:0] OP_IDLE = 2'h0;
	localparam logic [1:0] OP_RECORD = 2'h1;
	localparam logic [1:0] OP_PLAY = 2'h2;
	localparam logic [1:0] OP_CUE = 2'h3;
	typedef enum logic [1:0] {
		VSI_IDLE = 2'b00,
		VSI_SHIFT = 2'b01,
		VSI_DONE = 2'b11
	} vsi_state_t;
endpackage : vsi_pkg

// *** vsi_props.sv ***
// Port checker for the voice store core.
module vsi_props
	import vsi_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic select_n_in,
	input wire logic [1:0] op_mode_in,
	input wire logic array_end_in,
	input wire logic [MARKERS_PER_ROW-1:0] marker_hit_in,
	input wire logic miso_oe_out,
	input wire logic int_n_out,
	input wire logic int_oe_out,
	input wire logic sample_tick_out,
	input wire logic [FRAME_BITS-1:0] frame_out,
	input wire logic frame_valid_out,
	input wire logic read_event_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	logic ev;
	assign ev = array_end_in && op_mode_in inside {OP_RECORD, OP_PLAY}
		|| (|marker_hit_in) && op_mode_in inside {OP_PLAY, OP_CUE};
	////////////////////////////////
	a_int_level: assert property (int_n_out == 1'b0)
		else $error("interrupt level not low");
	a_int_cause: assert property ($rose(int_oe_out) |-> $past(ev))
		else $error("interrupt raised without event");
	a_int_raise: assert property (ev |=> int_oe_out)
		else $error("event did not raise interrupt");
	a_int_hold: assert property (int_oe_out && !$fell(select_n_in)
		|=> int_oe_out)
		else $error("interrupt dropped early");
	a_int_clear: assert property ($fell(select_n_in) && !ev
		|=> !int_oe_out)
		else $error("interrupt not cleared");
	a_int_quiet: assert property (!int_oe_out && !ev |=> !int_oe_out)
		else $error("interrupt without cause");
	a_tick_pulse: assert property (sample_tick_out
		|=> !sample_tick_out [*8])
		else $error("sample tick too frequent");
	a_frame_end: assert property (frame_valid_out
		|-> $past(select_n_in) && !$past(select_n_in, 2))
		else $error("frame valid off select rise");
	a_read_decode: assert property (read_event_out == (frame_valid_out
		&& frame_out[15:11] == CMD_READ_EVENT))
		else $error("read event decode wrong");
	a_miso_drive: assert property ($changed(select_n_in)
		|=> miso_oe_out == !$past(select_n_in))
		else $error("miso enable wrong");
	c_int: cover property (ev ##1 int_oe_out);
	c_read: cover property (read_event_out);
	c_tick: cover property (sample_tick_out);
	c_race: cover property ($fell(select_n_in) && ev);
endmodule : vsi_props

// *** vsi_host.sv ***
// Serial bus master model of the host controller.
module vsi_host (
	input wire logic clk_in,
	input wire logic miso_in,
	output logic sclk_out,
	output logic sel_n_out,
	output logic mosi_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge clk_in);
		sel_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			sclk_out = 1'b0;
			mosi_out = w[i];
			repeat (3) @(negedge clk_in);
			rx[i] = miso_in;
			sclk_out = 1'b1;
			repeat (3) @(negedge clk_in);
		end
		sclk_out = 1'b0;
		repeat (3) @(negedge clk_in);
		sel_n_out = 1'b1;
		// An idle data line must not keep the last bit as if it meant it.
		mosi_out = ~mosi_out;
		repeat (4) @(negedge clk_in);
	endtask : xfer
endmodule : vsi_host

// *** testbench.sv ***
// Self-checking bench for the voice store core.
module testbench
	import vsi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rstn = 1'b0, external_sample_clock = 1'b0, xen = 1'b0, aend = 1'b0;
	logic [1:0] op = OP_IDLE;
	logic [7:0] mk = 8'h00;
	logic sclk, seln, mosi, miso, moe, intn, ioe, tick, fv, re, ml = 1'b0;
	logic [15:0] fr, rx;
	int bad_count = 0, n_compared = 0, fvs = 0, res = 0, ticks = 0;
	// A released data line shows the opposite of its last driven bit.
	wire miso_w = moe ? miso : ~ml;
	wire int_line = ioe ? intn : 1'b1;
	always #25 clk = ~clk;
	always #488.281 external_sample_clock = xen & ~external_sample_clock;
	always @(posedge clk) begin
		if (moe) ml <= miso;
		fvs <= fvs + int'(fv === 1'b1);
		res <= res + int'(re === 1'b1);
		ticks <= ticks + int'(tick === 1'b1);
	end
	vsi_core vsi_core_i(.sys_clk_in(clk), .rstn_in(rstn), .sclk_in(sclk),
		.select_n_in(seln), .mosi_in(mosi), .external_sample_clock_in(external_sample_clock),
		.op_mode_in(op), .array_end_in(aend), .marker_hit_in(mk),
		.miso_out(miso), .miso_oe_out(moe), .int_n_out(intn),
		.int_oe_out(ioe), .sample_tick_out(tick), .frame_out(fr),
		.frame_valid_out(fv), .read_event_out(re));
	vsi_host vsi_host_i(.clk_in(clk), .miso_in(miso_w), .sclk_out(sclk),
		.sel_n_out(seln), .mosi_out(mosi));
	////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic ev(input logic [1:0] m, input logic a, input logic [7:0] k);
		@(negedge clk);
		op = m;
		aend = a;
		mk = k;
		@(negedge clk);
		aend = 1'b0;
		mk = 8'h00;
		repeat (3) @(negedge clk);
	endtask : ev
	task automatic rd(input logic [1:0] st, input logic [4:0] c, input int n);
		int f0;
		int r0;
		f0 = fvs;
		r0 = res;
		vsi_host_i.xfer({c, 11'h2a5}, n, rx);
		chk(rx[1:0], st);
		chk(int_line, 1'b1);
		chk(16'(fvs - f0), n == 16);
		chk(16'(res - r0), n == 16 && c == CMD_READ_EVENT);
		if (n == 16) chk(fr, {c, 11'h2a5});
	endtask : rd
	task automatic t_mem;
		ev(OP_RECORD, 1'b1, 8'h00);
		repeat (30) @(negedge clk);
		chk(int_line, 1'b0);
		rd(2'b01, CMD_READ_EVENT, 16);
		ev(OP_PLAY, 1'b1, 8'h00);
		rd(2'b01, 5'h1e, 16);
		$display("t_mem done");
	endtask : t_mem
	task automatic t_msg;
		for (int i = 0; i < 8; i++) begin
			ev(i[0] ? OP_PLAY : OP_CUE, 1'b0, 8'h01 << i);
			chk(int_line, 1'b0);
			rd(2'b10, CMD_READ_EVENT, 16);
		end
		$display("t_msg done");
	endtask : t_msg
	task automatic t_quiet;
		ev(OP_RECORD, 1'b0, 8'hff);
		ev(OP_CUE, 1'b1, 8'h00);
		ev(OP_IDLE, 1'b1, 8'hff);
		chk(int_line, 1'b1);
		rd(2'b00, CMD_READ_EVENT, 8);
		$display("t_quiet done");
	endtask : t_quiet
	// An event in the very cycle that select falls must survive the clear.
	task automatic t_race;
		fork
			vsi_host_i.xfer({5'h1e, 11'h2a5}, 16, rx);
			begin
				@(negedge clk);
				op = OP_RECORD;
				aend = 1'b1;
				@(negedge clk);
				aend = 1'b0;
			end
		join
		chk(rx[1:0], 2'b00);
		chk(int_line, 1'b0);
		rd(2'b01, 5'h1e, 16);
		$display("t_race done");
	endtask : t_race
	task automatic t_rst;
		ev(OP_RECORD, 1'b1, 8'h00);
		chk(int_line, 1'b0);
		rstn = 1'b0;
		@(negedge clk);
		chk(int_line, 1'b1);
		@(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		rd(2'b00, CMD_READ_EVENT, 16);
		$display("t_rst done");
	endtask : t_rst
	task automatic t_clk;
		int t0;
		t0 = ticks;
		xen = 1'b1;
		repeat (2000) @(negedge clk);
		xen = 1'b0;
		repeat (60) @(negedge clk);
		chk((ticks - t0) inside {51, 52}, 1'b1);
		t0 = ticks;
		repeat (200) @(negedge clk);
		chk(16'(ticks - t0), 16'h0000);
		$display("t_clk done");
	endtask : t_clk
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		chk(int_line, 1'b1);
		t_mem();
		t_msg();
		t_quiet();
		t_race();
		t_rst();
		t_clk();
		test_done();
	end
	initial begin
		#2000000;
		bad_count++;
		test_done();
	end
endmodule : testbench
bind vsi_core vsi_props vsi_props_i(.sys_clk_in, .rstn_in, .select_n_in,
	.op_mode_in, .array_end_in, .marker_hit_in, .miso_oe_out, .int_n_out,
	.int_oe_out, .sample_tick_out, .frame_out, .frame_valid_out,
	.read_event_out);
